// ---- tcs_top.sv ----
// Torque command selector: source choice, analog scaling and filtering, APB registers
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tcs_params.svh"
module tcs_top (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output wire logic [31:0] prdata,
    output wire logic        pready,
    output wire logic        pslverr,
    input  wire logic        torqueSelectBit0,
    input  wire logic        torqueSelectBit1,
    input  wire logic [15:0] analogTorqueMv,
    output wire logic [15:0] torqueCommand,
    output wire logic [15:0] torqueLimit,
    output wire logic        torqueLimitActive
);
    // APB slave state
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        pready_q;
    logic        pready_d;
    logic        pslverr_q;
    logic        pslverr_d;
    logic [9:0]  regIdx;
    logic        addrHit;
    logic        accessCycle;
    logic        writeCommit;

    // Configuration registers
    logic [15:0] fullScale_q;
    logic [15:0] fullScale_d;
    logic [2:0]  control_q;
    logic [2:0]  control_d;
    tcs_pkg::tcs_pct_t presetVal [3];

    // Datapath
    logic [1:0]         selCode;
    logic               zeroMode;
    logic               torqueLoop;
    logic signed [15:0] analogClamped;
    logic signed [32:0] scaledProd;
    logic signed [32:0] scaledQuot;
    logic signed [15:0] scaled_q;
    logic signed [15:0] scaled_d;
    logic signed [15:0] selected;
    logic [7:0]         tickCnt_q;
    logic [7:0]         tickCnt_d;
    logic               tick_q;
    logic               tick_d;
    logic signed [15:0] cmd_q;
    logic signed [15:0] cmd_d;
    logic signed [15:0] limit_q;
    logic signed [15:0] limit_d;
    logic               limitActive_q;
    logic               limitActive_d;

    tcs_lpf_if lpfLink ();

    function automatic logic signed [15:0] clampPct(input logic signed [15:0] v);
        if (v > `TCS_PRESET_LIMIT) begin
            return `TCS_PRESET_LIMIT;
        end else if (v < -`TCS_PRESET_LIMIT) begin
            return -`TCS_PRESET_LIMIT;
        end
        return v;
    endfunction : clampPct

    // Bus decode; one wait state, answer registered
    assign regIdx      = paddr[11:2];
    assign accessCycle = psel & penable & ~pready_q;
    assign writeCommit = psel & penable & pready_q & pwrite & ~pslverr_q;

    always_comb begin
        addrHit = (paddr[1:0] == 2'h0) &&
                  (regIdx == `TCS_IDX_PRESET_ONE || regIdx == `TCS_IDX_PRESET_TWO ||
                   regIdx == `TCS_IDX_PRESET_THREE || regIdx == `TCS_IDX_CONTROL ||
                   regIdx == `TCS_IDX_STATUS || regIdx == `TCS_IDX_FULL_SCALE);
        pready_d  = accessCycle;
        pslverr_d = accessCycle & ~addrHit;
        prdata_d  = 32'h0000_0000;
        if (accessCycle && addrHit && !pwrite) begin
            unique case (regIdx)
                `TCS_IDX_PRESET_ONE:   prdata_d = {{16{presetVal[0][15]}}, presetVal[0]};
                `TCS_IDX_PRESET_TWO:   prdata_d = {{16{presetVal[1][15]}}, presetVal[1]};
                `TCS_IDX_PRESET_THREE: prdata_d = {{16{presetVal[2][15]}}, presetVal[2]};
                `TCS_IDX_CONTROL:      prdata_d = {29'h0000_0000, control_q};
                `TCS_IDX_STATUS:       prdata_d = {limit_q, cmd_q};
                default:               prdata_d = {16'h0000, fullScale_q};
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Full-scale setting is clipped to its legal span on write
    always_comb begin
        fullScale_d = fullScale_q;
        control_d   = control_q;
        if (writeCommit && regIdx == `TCS_IDX_FULL_SCALE) begin
            fullScale_d = (pwdata[15:0] > `TCS_FULL_SCALE_MAX) ? `TCS_FULL_SCALE_MAX : pwdata[15:0];
        end
        if (writeCommit && regIdx == `TCS_IDX_CONTROL) begin
            control_d = pwdata[2:0];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            fullScale_q <= `TCS_FULL_SCALE_RST;
            control_q   <= `TCS_CONTROL_RST;
        end else begin
            fullScale_q <= fullScale_d;
            control_q   <= control_d;
        end
    end

    // Preset torque registers, held within the preset span
    for (genvar g = 0; g < 3; g++) begin : gPreset
        logic signed [15:0] val_q;
        logic signed [15:0] val_d;
        always_comb begin
            val_d = val_q;
            if (writeCommit && regIdx == `TCS_IDX_PRESET_ONE + 10'(g)) begin
                val_d = clampPct(pwdata[15:0]);
            end
        end
        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                val_q <= `TCS_PRESET_RST;
            end else begin
                val_q <= val_d;
            end
        end
        assign presetVal[g] = val_q;
    end

    // Analog path: saturate, scale by full-scale over 1000 (mV in, 0.1 % out)
    assign selCode    = {torqueSelectBit1, torqueSelectBit0};
    assign zeroMode   = control_q[`TCS_CTRL_ZERO_BIT];
    assign torqueLoop = (control_q[`TCS_CTRL_LOOP_MSB:`TCS_CTRL_LOOP_LSB] == tcs_pkg::TCS_LOOP_TORQUE);

    always_comb begin
        analogClamped = $signed(analogTorqueMv);
        if ($signed(analogTorqueMv) > `TCS_ANALOG_SPAN_MV) begin
            analogClamped = `TCS_ANALOG_SPAN_MV;
        end else if ($signed(analogTorqueMv) < -`TCS_ANALOG_SPAN_MV) begin
            analogClamped = -`TCS_ANALOG_SPAN_MV;
        end
        scaledProd = 33'(analogClamped) * $signed({17'h00000, fullScale_q});
        scaledQuot = scaledProd / `TCS_SCALE_DIV;
        scaled_d   = scaledQuot[15:0];
        tick_d     = (tickCnt_q == 8'(`TCS_LPF_TICK_CYC - 1));
        tickCnt_d  = tick_d ? 8'h00 : tickCnt_q + 8'h01;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            scaled_q  <= 16'sh0000;
            tickCnt_q <= 8'h00;
            tick_q    <= 1'b0;
        end else begin
            scaled_q  <= scaled_d;
            tickCnt_q <= tickCnt_d;
            tick_q    <= tick_d;
        end
    end

    assign lpfLink.sample = scaled_q;
    assign lpfLink.tick   = tick_q;

    tcs_lpf uLpf (
        .clock (clock),
        .reset (reset),
        .lpf   (lpfLink.filt)
    );

    // Source choice; presets take effect the cycle after the select bits change
    always_comb begin
        unique case (selCode)
            2'h1:    selected = presetVal[0];
            2'h2:    selected = presetVal[1];
            2'h3:    selected = presetVal[2];
            default: selected = zeroMode ? 16'sh0000 : lpfLink.filtered;
        endcase
        cmd_d         = torqueLoop ? selected : 16'sh0000;
        limit_d       = torqueLoop ? 16'sh0000 : selected;
        limitActive_d = ~torqueLoop;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cmd_q         <= 16'sh0000;
            limit_q       <= 16'sh0000;
            limitActive_q <= 1'b0;
        end else begin
            cmd_q         <= cmd_d;
            limit_q       <= limit_d;
            limitActive_q <= limitActive_d;
        end
    end

    assign prdata            = prdata_q;
    assign pready            = pready_q;
    assign pslverr           = pslverr_q;
    assign torqueCommand     = cmd_q;
    assign torqueLimit       = limit_q;
    assign torqueLimitActive = limitActive_q;

    // Checks
    logic fsWritten_q;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            fsWritten_q <= 1'b0;
        end else if (writeCommit && regIdx == `TCS_IDX_FULL_SCALE) begin
            fsWritten_q <= 1'b1;
        end
    end

    default clocking cbTcs @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence sAccess;
        psel && penable && !pready;
    endsequence
    sequence sAnswer;
        pready ##1 !pready;
    endsequence
    sequence sZeroTorque;
        selCode == 2'h0 && zeroMode && torqueLoop;
    endsequence
    sequence sAnalogSel;
        selCode == 2'h0 && !zeroMode;
    endsequence

    a_apb_answer:
        assert property (sAccess |=> sAnswer)
        else $error("APB answer not one cycle after access");
    a_zero_cmd:
        assert property (sZeroTorque |=> torqueCommand == 16'h0000 && !torqueLimitActive)
        else $error("Zero command mode did not give zero");
    a_analog_torque:
        assert property (sAnalogSel and torqueLoop |=> $signed(torqueCommand) == $past(lpfLink.filtered))
        else $error("Analog torque path not selected");
    a_preset_pick:
        assert property (selCode == 2'h2 && torqueLoop |=> $signed(torqueCommand) == $past(presetVal[1]))
        else $error("Preset two not selected");
    a_preset_immediate:
        assert property ($changed(selCode) && selCode == 2'h3 && torqueLoop
                         |=> $signed(torqueCommand) == $past(presetVal[2]))
        else $error("Preset not applied on select change");
    a_limit_route:
        assert property (!torqueLoop |=> torqueLimitActive && torqueCommand == 16'h0000
                         && $signed(torqueLimit) == $past(selected))
        else $error("Speed or position mode did not route to limit");
    a_mode_path:
        assert property (selCode == 2'h0 && zeroMode && !torqueLoop |=> torqueLimit == 16'h0000)
        else $error("Zero mode ignored on limit path");
    a_scale_full:
        assert property (analogClamped == `TCS_ANALOG_SPAN_MV && fullScale_q == 16'h03E8
                         |=> scaled_q == 16'sh2710)
        else $error("Full span input not scaled to full scale");
    a_fs_default:
        assert property (!fsWritten_q |-> fullScale_q == `TCS_FULL_SCALE_RST)
        else $error("Full-scale setting not at its reset value");
    a_analog_sat:
        assert property (1'b1 |=> scaled_q <= 16'sh2710 && scaled_q >= -16'sh2710)
        else $error("Scaled analog value out of span");
    a_filter_step:
        assert property (!lpfLink.tick |=> $stable(lpfLink.filtered))
        else $error("Filter output moved without a tick");
endmodule : tcs_top
`default_nettype wire

// ---- tcs_params.svh ----
// Register map, reset values and timing constants of the torque command selector
`ifndef TCS_PARAMS_SVH
`define TCS_PARAMS_SVH

`define TCS_IDX_PRESET_ONE   10'h140
`define TCS_IDX_PRESET_TWO   10'h141
`define TCS_IDX_PRESET_THREE 10'h142
`define TCS_IDX_CONTROL      10'h143
`define TCS_IDX_STATUS       10'h144
`define TCS_IDX_FULL_SCALE   10'h152

`define TCS_FULL_SCALE_RST   16'h0064
`define TCS_FULL_SCALE_MAX   16'h03E8
`define TCS_PRESET_RST       16'h0000
`define TCS_CONTROL_RST      3'h0
`define TCS_CTRL_ZERO_BIT    0
`define TCS_CTRL_LOOP_LSB    1
`define TCS_CTRL_LOOP_MSB    2

`define TCS_ANALOG_SPAN_MV   16'sh2710
`define TCS_PRESET_LIMIT     16'sh125C
`define TCS_SCALE_DIV        33'sh0000003E8

`define TCS_CLK_NS           5
`define TCS_LPF_TICK_NS      1000
`define TCS_LPF_TICK_CYC     (`TCS_LPF_TICK_NS / `TCS_CLK_NS)
`define TCS_LPF_SHIFT        4

`endif

// ---- tcs_pkg.sv ----
// Types shared by the torque command selector modules
package tcs_pkg;
    typedef logic signed [15:0] tcs_pct_t;
    typedef enum logic [1:0] {
        TCS_LOOP_TORQUE   = 2'h0,
        TCS_LOOP_SPEED    = 2'h1,
        TCS_LOOP_POSITION = 2'h2
    } tcs_loop_t;
endpackage : tcs_pkg

// ---- tcs_lpf_if.sv ----
// Link between the selector and its analog low-pass filter
`timescale 1ns/1ps
`default_nettype none
interface tcs_lpf_if;
    tcs_pkg::tcs_pct_t sample;
    tcs_pkg::tcs_pct_t filtered;
    logic              tick;
    modport drv  (output sample, output tick, input filtered);
    modport filt (input sample, input tick, output filtered);
endinterface : tcs_lpf_if
`default_nettype wire

// ---- tcs_lpf.sv ----
// First-order low-pass filter on the scaled analog torque path
`timescale 1ns/1ps
`default_nettype none
`include "tcs_params.svh"
module tcs_lpf (
    input wire logic clock,
    input wire logic reset,
    tcs_lpf_if.filt  lpf
);
    logic signed [15:0] out_q;
    logic signed [15:0] out_d;
    logic signed [16:0] diff;
    logic signed [16:0] step;
    logic signed [16:0] sum;

    // Moves a fraction of the error each tick; result always lies between old output and input
    always_comb begin
        diff  = {lpf.sample[15], lpf.sample} - {out_q[15], out_q};
        step  = diff >>> `TCS_LPF_SHIFT;
        sum   = {out_q[15], out_q} + step;
        out_d = out_q;
        if (lpf.tick) begin
            out_d = sum[15:0];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            out_q <= 16'sh0000;
        end else begin
            out_q <= out_d;
        end
    end

    assign lpf.filtered = out_q;
endmodule : tcs_lpf
`default_nettype wire

// ---- tcs_ctrl_model.sv ----
// Outside motion controller: drives the select inputs and the digitised analog voltage
`timescale 1ns/1ps
`default_nettype none
module tcs_ctrl_model (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [1:0]  selCode,
    input  wire logic [15:0] mvReq,
    output var  logic        torqueSelectBit0,
    output var  logic        torqueSelectBit1,
    output var  logic [15:0] analogTorqueMv
);
    // Contact closed drives 1, open drives 0
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            torqueSelectBit0 <= 1'b0;
            torqueSelectBit1 <= 1'b0;
            analogTorqueMv   <= 16'h0000;
        end else begin
            torqueSelectBit0 <= selCode[0];
            torqueSelectBit1 <= selCode[1];
            analogTorqueMv   <= mvReq;
        end
    end
endmodule : tcs_ctrl_model
`default_nettype wire

// ---- tb_torque_command_selector.sv ----
// Self-checking testbench of the torque command selector
`timescale 1ns/1ps
`default_nettype none
`include "tcs_params.svh"
module tb_torque_command_selector;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, b0, b1, err, act;
    logic [1:0]  selCode = 2'h0;
    logic [15:0] mvReq = 16'h0000, mv, cmd, lim;
    int          miscompares = 0, cmp_count = 0;
    localparam logic [11:0] A1 = {`TCS_IDX_PRESET_ONE, 2'b00}, A2 = {`TCS_IDX_PRESET_TWO, 2'b00};
    localparam logic [11:0] A3 = {`TCS_IDX_PRESET_THREE, 2'b00}, AC = {`TCS_IDX_CONTROL, 2'b00};
    localparam logic [11:0] AS = {`TCS_IDX_STATUS, 2'b00}, AF = {`TCS_IDX_FULL_SCALE, 2'b00};
    logic [15:0] pre [3] = '{16'h0100, 16'h125C, 16'hFED4};

    tcs_ctrl_model tcs_ctrl_model_i (.clock(clock), .reset(reset), .selCode(selCode), .mvReq(mvReq),
        .torqueSelectBit0(b0), .torqueSelectBit1(b1), .analogTorqueMv(mv));
    tcs_top tcs_top_i (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .torqueSelectBit0(b0), .torqueSelectBit1(b1), .analogTorqueMv(mv), .torqueCommand(cmd),
        .torqueLimit(lim), .torqueLimitActive(act));

    initial begin
        forever #2.5 clock = ~clock;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic near(input string name, input int exp, input logic [15:0] got);
        cmp_count++;
        if ($signed(got) >= exp - 16 && $signed(got) <= exp) begin
        end else begin
            miscompares++;
            $display("unexpected %s: expected %0d seen %0d", name, exp, $signed(got));
        end
    endtask : near

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // Request stands until pready is seen high at a rising edge, for at most 20 edges; data taken at that edge
        for (n = 0; n < 20; n++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        if (n == 20) chk("pready", 32'h1, 32'h0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic drive(input logic [1:0] c, input logic [15:0] m);
        @(posedge clock);
        selCode <= c;
        mvReq <= m;
        repeat (3) @(posedge clock);
        @(negedge clock);
    endtask : drive

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up

    initial begin
        #400000;
        miscompares++;
        wrap_up();
    end

    initial begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        apb(0, AF, 0); chk("full scale", 32'h64, rd);
        apb(0, A1, 0); chk("preset one", 32'h0, rd);
        apb(0, AC, 0); chk("control", 32'h0, rd);
        $display("test reset done");
        apb(1, A1, 32'h100);
        apb(1, A2, 32'h1388);
        apb(1, A3, 32'hFFFFFED4);
        apb(0, A2, 0); chk("preset two clip", 32'h125C, rd);
        apb(0, A3, 0); chk("preset three", 32'hFFFFFED4, rd);
        apb(1, AF, 32'h7D0);
        apb(0, AF, 0); chk("full scale clip", 32'h3E8, rd);
        apb(1, AF, 32'h64);
        apb(0, 12'h514, 0); chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        $display("test registers done");
        for (int i = 1; i < 4; i++) begin
            drive(i[1:0], 16'h1388);
            chk("preset command", {16'h0, pre[i-1]}, {16'h0, cmd});
        end
        apb(1, AC, 32'h1);
        drive(2'h0, 16'h1388); chk("zero mode", 32'h0, {16'h0, cmd});
        $display("test select done");
        apb(1, AC, 32'h0);
        drive(2'h0, 16'h1388);
        repeat (14000) @(posedge clock);
        near("analog 5 V", 500, cmd);
        drive(2'h0, 16'h2EE0);
        repeat (14000) @(posedge clock);
        near("analog clamp", 1000, cmd);
        $display("test analog done");
        apb(1, AC, 32'h2);
        drive(2'h2, 16'h2EE0);
        chk("speed command", 32'h0, {16'h0, cmd});
        chk("speed limit", 32'h125C, {16'h0, lim});
        chk("limit active", 32'h1, {31'h0, act});
        apb(0, AS, 0); chk("status", 32'h125C0000, rd);
        drive(2'h0, 16'h2EE0); near("analog limit", 1000, lim);
        apb(1, AC, 32'h4);
        drive(2'h0, 16'h2EE0); chk("position active", 32'h1, {31'h0, act});
        apb(1, AC, 32'h3);
        drive(2'h0, 16'h2EE0); chk("zero limit", 32'h0, {16'h0, lim});
        $display("test limit done");
        // Largest setting: a clipped 12 V input gives 1000 percent, 10000 in 0.1 % steps
        apb(1, AC, 32'h0);
        apb(1, AF, 32'h3E8);
        drive(2'h0, 16'h2EE0);
        repeat (24000) @(posedge clock);
        near("analog full scale", 10000, cmd);
        $display("test full scale done");
        wrap_up();
    end
endmodule : tb_torque_command_selector
`default_nettype wire
